// ==== src/dpdbs_pkg.sv ====
// Shared constants and types for the two-word burst SRAM port logic
package dpdbs_pkg;
    // Locations modelled in the array (address bus width)
    localparam int ADDR_W = 10;
    // One data word on the read or write port
    localparam int WORD_W = 18;
    // Width of one byte lane, each with its own write select
    localparam int LANE_W = 9;
    // Byte lanes per word and per two-word burst
    localparam int LANES_WORD = 2;
    localparam int LANES = 4;
    // Two words held by every location
    localparam int BURST_W = 36;
    // Write staging queue between input registers and array
    localparam int FIFO_DEPTH = 32;
    localparam int FIFO_PTR_W = 5;
    // Queue entry: {address, lane enables, two words}
    localparam int ENTRY_W = ADDR_W + LANES + BURST_W;
    // Slot codes: K rise carries the read, K# rise the write
    localparam logic PHASE_READ = 1'b0;
    localparam logic PHASE_WRITE = 1'b1;
    localparam logic PHASE_RST = 1'b0;
    // Fast clock edges per K period
    localparam int CLK_PER_K = 2;
    // Read latency in half K periods: 1 cycle and 1.5 cycles
    localparam int LAT_HALF_LOW = 1 * CLK_PER_K;
    localparam int LAT_HALF_HIGH = 3 * CLK_PER_K / 2;
    // Idle level of the active-low selects
    localparam logic SEL_IDLE = 1'b1;
    // Array write engine states
    typedef enum logic [1:0] {
        ENG_IDLE = 2'b01,
        ENG_UPPER = 2'b10
    } dpdbs_eng_t;
endpackage : dpdbs_pkg

// ==== src/dpdbs_fifo.sv ====
// Write staging queue with lane-wise lookup of pending entries
`timescale 1ns/10ps
module dpdbs_fifo #(
    parameter int KW = 10,
    parameter int LN = 4,
    parameter int LW = 9,
    parameter int DEPTH = 32,
    parameter int PW = 5
) (
    input wire logic clk,
    input wire logic srst,
    input wire logic inValid,
    input wire logic [KW+LN+LN*LW-1:0] inData,
    output logic inReady,
    output logic outValid,
    output logic [KW+LN+LN*LW-1:0] outData,
    input wire logic outReady,
    input wire logic [KW-1:0] lookKey,
    output logic [LN-1:0] lookHit,
    output logic [LN*LW-1:0] lookData
);
    localparam int W = KW + LN + LN * LW;
    // Entry storage
    logic [W-1:0] mem [DEPTH];
    logic [PW-1:0] wrPtr_reg;
    logic [PW-1:0] rdPtr_reg;
    // Occupancy, one bit wider than the pointers
    logic [PW:0] count_reg;
    logic push;
    logic pop;

    // Honest flags straight from the occupancy
    assign inReady = (count_reg != (PW+1)'(DEPTH));
    assign outValid = (count_reg != '0);
    assign outData = mem[rdPtr_reg];
    assign push = inValid && inReady;
    assign pop = outValid && outReady;

    // Entry writes; no reset needed on storage
    always_ff @(posedge clk) begin
        if (push) begin
            mem[wrPtr_reg] <= inData;
        end
    end

    // Pointers and occupancy
    always_ff @(posedge clk) begin
        if (srst) begin
            wrPtr_reg <= '0;
            rdPtr_reg <= '0;
            count_reg <= '0;
        end else begin
            if (push) begin
                wrPtr_reg <= wrPtr_reg + 1'b1;
            end
            if (pop) begin
                rdPtr_reg <= rdPtr_reg + 1'b1;
            end
            count_reg <= count_reg + (PW+1)'(push) - (PW+1)'(pop);
        end
    end

    // Oldest to newest, so the newest matching lane wins
    always_comb begin
        logic [PW-1:0] idx;
        idx = '0;
        lookHit = '0;
        lookData = '0;
        for (int i = 0; i < DEPTH; i++) begin
            idx = rdPtr_reg + PW'(i);
            if ((PW+1)'(i) < count_reg &&
                mem[idx][W-1 -: KW] == lookKey) begin
                for (int l = 0; l < LN; l++) begin
                    if (mem[idx][LN*LW+l]) begin
                        lookHit[l] = 1'b1;
                        lookData[l*LW +: LW] = mem[idx][l*LW +: LW];
                    end
                end
            end
        end
    end
endmodule : dpdbs_fifo

// ==== src/dpdbs_top.sv ====
// Two-word burst SRAM with separate DDR read and write ports
//
// Behaviour
// RULE1: Read and write addresses alternate K edges
// RULE2: Each location holds two words, burst both
// RULE3: Mode high gives 1.5 cycle read latency
// RULE4: Mode low gives 1 cycle read latency
// RULE5: One word per true and complement edge
// RULE6: All inputs captured in input registers; pllModeSelect is used unregistered
// RULE7: Read data leaves from output registers
// RULE8: Separate read and write port selects
// RULE9: Reads and writes proceed concurrently, never stall
// RULE10: Separate data in and out buses
// RULE11: Echo clock pair aligned with read data
// RULE12: Captured writes complete self-timed into array
// RULE13: Reads return newest data, including in-flight
// RULE14: Selects active low, sampled with address
// RULE15: First burst word is lower position
//
// One fast clock edge stands for one rising edge of either
// input clock: the edge with phase PHASE_READ is the true
// clock rise, the other the complement rise.
`timescale 1ns/10ps
module dpdbs_top (
    input wire logic clk,
    input wire logic srst,
    input wire logic pllModeSelect,
    input wire logic [dpdbs_pkg::ADDR_W-1:0] addr,
    input wire logic readPortSelectN,
    input wire logic writePortSelectN,
    input wire logic [dpdbs_pkg::WORD_W-1:0] writeData,
    input wire logic [dpdbs_pkg::LANES_WORD-1:0] byteWriteSelectN,
    output logic [dpdbs_pkg::WORD_W-1:0] readData,
    output logic readValid,
    output logic echoTimingOut,
    output logic echoTimingOutN,
    output logic writeBusy
);
    // ************************************************
    // Declarations
    // ************************************************
    localparam int AW = dpdbs_pkg::ADDR_W;
    localparam int WW = dpdbs_pkg::WORD_W;
    localparam int BW = dpdbs_pkg::BURST_W;
    localparam int LN = dpdbs_pkg::LANES;
    localparam int LW = dpdbs_pkg::LANE_W;
    localparam int LNW = dpdbs_pkg::LANES_WORD;
    localparam int EW = dpdbs_pkg::ENTRY_W;
    // Stages of read pipeline before the serializer
    localparam int PIPE_N = dpdbs_pkg::LAT_HALF_HIGH - 1;

    // Slot tracker: which input clock rose at this edge
    logic phase_reg;
    // Input capture registers
    logic capPhase_reg;
    logic [AW-1:0] capAddr_reg;
    logic capReadSelN_reg;
    logic capWriteSelN_reg;
    logic [WW-1:0] capData_reg;
    logic [LNW-1:0] capMaskN_reg;
    // First half of a write burst awaiting its second word
    logic asmValid_reg;
    logic [AW-1:0] asmAddr_reg;
    logic [WW-1:0] asmWord0_reg;
    logic [LNW-1:0] asmMask0_reg;
    // Complete write entry offered to the queue
    logic [EW-1:0] pushEntry;
    logic pushValid;
    logic pushReady;
    logic [LN-1:0] pushMask;
    // Queue head and array write engine
    logic headValid;
    logic [EW-1:0] headEntry;
    logic headPop;
    dpdbs_pkg::dpdbs_eng_t eng_reg;
    // Storage array: two words per location
    logic [BW-1:0] mem [2**AW];
    // Read lookup
    logic readReq;
    logic [LN-1:0] pendHit;
    logic [BW-1:0] pendData;
    logic [BW-1:0] readMerged;
    // Read pipeline stages and serializer
    logic pipeValid_reg [PIPE_N];
    logic [BW-1:0] pipeData_reg [PIPE_N];
    logic [WW-1:0] holdWord_reg;
    logic holdValid_reg;
    logic tapValid;
    logic [BW-1:0] tapData;
    int tapIdx;
    logic launchPhase;
    // Output flops
    logic [WW-1:0] readData_reg;
    logic readValid_reg;
    logic echo_reg;
    logic echoN_reg;
    logic writeBusy_reg;

    // Active-low lane selects to lane enables
    function automatic logic [LNW-1:0] lane_en(
        input logic [LNW-1:0] selN
    );
        lane_en = ~selN;
    endfunction : lane_en

    // ************************************************
    // Slot tracking and input capture
    // ************************************************

    // Alternating slots; first edge after reset is a read slot
    always_ff @(posedge clk) begin
        if (srst) begin
            phase_reg <= dpdbs_pkg::PHASE_RST;
        end else begin
            phase_reg <= ~phase_reg;
        end
    end

    // RULE6: register every address, select and data input
    // Every address, select and data pin passes a register before any decode, so the
    // controller sees one fixed setup point per edge.
    always_ff @(posedge clk) begin
        if (srst) begin
            capPhase_reg <= dpdbs_pkg::PHASE_RST;
            capAddr_reg <= '0;
            capReadSelN_reg <= dpdbs_pkg::SEL_IDLE;
            capWriteSelN_reg <= dpdbs_pkg::SEL_IDLE;
            capData_reg <= '0;
            capMaskN_reg <= '1;
        end else begin
            capPhase_reg <= phase_reg;
            capAddr_reg <= addr;
            capReadSelN_reg <= readPortSelectN;
            capWriteSelN_reg <= writePortSelectN;
            capData_reg <= writeData;
            capMaskN_reg <= byteWriteSelectN;
        end
    end

    // ************************************************
    // Write port
    // ************************************************

    // RULE1: write address taken in complement slot
    // RULE14: write select honoured only in its own slot
    always_ff @(posedge clk) begin
        if (srst) begin
            asmValid_reg <= 1'b0;
            asmAddr_reg <= '0;
            asmWord0_reg <= '0;
            asmMask0_reg <= '0;
        end else begin
            asmValid_reg <= (capPhase_reg == dpdbs_pkg::PHASE_WRITE)
                && !capWriteSelN_reg;
            asmAddr_reg <= capAddr_reg;
            // RULE5: first word rides the address edge
            asmWord0_reg <= capData_reg;
            asmMask0_reg <= lane_en(capMaskN_reg);
        end
    end

    // RULE15: lower word in low lanes, upper word above
    // RULE2: both words form one queue entry
    assign pushMask = {lane_en(capMaskN_reg), asmMask0_reg};
    assign pushEntry = {asmAddr_reg, pushMask, capData_reg,
        asmWord0_reg};
    assign pushValid = asmValid_reg;

    // Queue between capture and the array
    dpdbs_fifo #(
        .KW(AW),
        .LN(LN),
        .LW(LW),
        .DEPTH(dpdbs_pkg::FIFO_DEPTH),
        .PW(dpdbs_pkg::FIFO_PTR_W)
    ) u_wrq (
        .clk(clk),
        .srst(srst),
        .inValid(pushValid),
        .inData(pushEntry),
        .inReady(pushReady),
        .outValid(headValid),
        .outData(headEntry),
        .outReady(headPop),
        .lookKey(capAddr_reg),
        .lookHit(pendHit),
        .lookData(pendData)
    );

    // Entry leaves only after its upper word is in the array
    assign headPop = (eng_reg == dpdbs_pkg::ENG_UPPER);

    // RULE12: self-timed array write engine
    // One word per edge; the queue absorbs any backlog.
    always_ff @(posedge clk) begin
        if (srst) begin
            eng_reg <= dpdbs_pkg::ENG_IDLE;
        end else begin
            unique case (eng_reg)
                // Start on a waiting entry
                dpdbs_pkg::ENG_IDLE: begin
                    if (headValid) begin
                        eng_reg <= dpdbs_pkg::ENG_UPPER;
                    end
                end
                // Upper word done, back to idle
                dpdbs_pkg::ENG_UPPER: begin
                    eng_reg <= dpdbs_pkg::ENG_IDLE;
                end
            endcase
        end
    end

    // Lane writes: lower lanes in idle, upper lanes next
    always_ff @(posedge clk) begin
        for (int l = 0; l < LN; l++) begin
            if (headValid && headEntry[BW+l] &&
                ((l < LNW) == (eng_reg == dpdbs_pkg::ENG_IDLE))) begin
                mem[headEntry[EW-1 -: AW]][l*LW +: LW] <=
                    headEntry[l*LW +: LW];
            end
        end
    end

    // Back-pressure seen by the controller, registered
    always_ff @(posedge clk) begin
        if (srst) begin
            writeBusy_reg <= 1'b0;
        end else begin
            writeBusy_reg <= !pushReady;
        end
    end

    // ************************************************
    // Read port
    // ************************************************

    // RULE1: read address taken in true clock slot
    // RULE14: read select honoured only in its own slot
    assign readReq = (capPhase_reg == dpdbs_pkg::PHASE_READ)
        && !capReadSelN_reg;

    // RULE13: array, then queued writes, then burst in assembly
    // The write whose address came one slot earlier is merged
    // too, so a read right behind a write still sees it.
    always_comb begin
        readMerged = mem[capAddr_reg];
        for (int l = 0; l < LN; l++) begin
            if (pendHit[l]) begin
                readMerged[l*LW +: LW] = pendData[l*LW +: LW];
            end
            if (pushValid && pushReady && pushMask[l] &&
                asmAddr_reg == capAddr_reg) begin
                readMerged[l*LW +: LW] = pushEntry[l*LW +: LW];
            end
        end
    end

    // RULE9: read pipeline never waits on the write side
    always_ff @(posedge clk) begin
        if (srst) begin
            for (int s = 0; s < PIPE_N; s++) begin
                pipeValid_reg[s] <= 1'b0;
                pipeData_reg[s] <= '0;
            end
        end else begin
            pipeValid_reg[0] <= readReq;
            pipeData_reg[0] <= readMerged;
            for (int s = 1; s < PIPE_N; s++) begin
                pipeValid_reg[s] <= pipeValid_reg[s-1];
                pipeData_reg[s] <= pipeData_reg[s-1];
            end
        end
    end

    // RULE3: tap one stage later in high mode
    // RULE4: tap first stage in low mode
    // The mode pin is treated as static; changing it with a
    // read in flight may drop or repeat that burst.
    always_comb begin
        tapIdx = pllModeSelect ? dpdbs_pkg::LAT_HALF_HIGH - 2
            : dpdbs_pkg::LAT_HALF_LOW - 2;
        tapValid = pipeValid_reg[tapIdx];
        tapData = pipeData_reg[tapIdx];
    end

    // RULE7: read words leave from output registers
    // RULE5: word per edge, lower then upper
    // RULE10: dedicated output bus, no turnaround gap
    always_ff @(posedge clk) begin
        if (srst) begin
            readData_reg <= '0;
            readValid_reg <= 1'b0;
            holdWord_reg <= '0;
            holdValid_reg <= 1'b0;
        end else if (tapValid) begin
            // RULE15: lower burst word first
            readData_reg <= tapData[WW-1:0];
            readValid_reg <= 1'b1;
            holdWord_reg <= tapData[BW-1:WW];
            holdValid_reg <= 1'b1;
        end else if (holdValid_reg) begin
            // Upper word on the following edge
            readData_reg <= holdWord_reg;
            readValid_reg <= 1'b1;
            holdValid_reg <= 1'b0;
        end else begin
            // Idle: keep last word, flag low
            readValid_reg <= 1'b0;
        end
    end

    // ************************************************
    // Echo clocks
    // ************************************************

    // First words land in read slots in low mode, else the
    // complement slot
    assign launchPhase = pllModeSelect ? dpdbs_pkg::PHASE_WRITE
        : dpdbs_pkg::PHASE_READ;

    // RULE11: echo high on edges launching a first word
    // Free-running so the controller can lock before reads.
    always_ff @(posedge clk) begin
        if (srst) begin
            echo_reg <= 1'b0;
            echoN_reg <= 1'b1;
        end else begin
            echo_reg <= (phase_reg == launchPhase);
            echoN_reg <= (phase_reg != launchPhase);
        end
    end

    // ************************************************
    // Outputs
    // ************************************************

    // RULE8: each port gated by its own select above
    assign readData = readData_reg;
    assign readValid = readValid_reg;
    assign echoTimingOut = echo_reg;
    assign echoTimingOutN = echoN_reg;
    assign writeBusy = writeBusy_reg;
endmodule : dpdbs_top

// ==== testbench/dpdbs_properties.sv ====
// Port checks for the two-word burst SRAM
`timescale 1ns/10ps
module dpdbs_properties (
    input wire logic clk,
    input wire logic srst,
    input wire logic pllModeSelect,
    input wire logic readPortSelectN,
    input wire logic [17:0] readData,
    input wire logic readValid,
    input wire logic echoTimingOut,
    input wire logic echoTimingOutN,
    input wire logic writeBusy
);
    // Slot tracker: high on read-slot edges, read slot first after reset
    logic rdSlot_reg;
    logic rdTake;
    always_ff @(posedge clk) begin
        rdSlot_reg <= srst | !rdSlot_reg;
    end
    // A read is taken only in its own slot
    assign rdTake = rdSlot_reg & !readPortSelectN;
    default clocking cb @(posedge clk); endclocking
    default disable iff (srst);
    // Two words on back-to-back edges
    // The flag is registered, so it is first seen one edge after launch
    sequence s_low;
        ##3 readValid ##1 readValid;
    endsequence
    sequence s_high;
        ##4 readValid ##1 readValid;
    endsequence
    a_low_latency: assert property (
        rdTake && !pllModeSelect |-> s_low)
        else $error("Late burst in short mode");
    // one and a half cycle latency
    a_high_latency: assert property (
        rdTake && pllModeSelect |-> s_high)
        else $error("Late burst in long mode");
    a_valid_cause: assert property (
        readValid |-> (pllModeSelect ? $past(rdTake, 4) || $past(rdTake, 5)
        : $past(rdTake, 3) || $past(rdTake, 4)))
        else $error("Read data without a selected read");
    a_echo_pair: assert property (
        echoTimingOutN == !echoTimingOut)
        else $error("Echo pair not complementary");
    // echo changes on every edge once running
    a_echo_toggle: assert property (
        !$past(srst) && !$past(srst, 2) |-> $changed(echoTimingOut))
        else $error("Echo missed a toggle");
    // first word aligned with echo high
    a_echo_align: assert property (
        $rose(readValid) |-> echoTimingOut)
        else $error("First word not aligned with echo");
    a_data_hold: assert property (
        !readValid |-> $stable(readData))
        else $error("Read data moved while idle");
    // legal traffic never fills the write queue
    a_no_busy: assert property (
        !writeBusy)
        else $error("Write queue full under legal traffic");
endmodule : dpdbs_properties

bind dpdbs_top dpdbs_properties u_props (.clk, .srst, .pllModeSelect,
    .readPortSelectN, .readData, .readValid, .echoTimingOut,
    .echoTimingOutN, .writeBusy);

// ==== testbench/dpdbs_ctrl.sv ====
// Controller model driving the shared address bus and write port
`timescale 1ns/10ps
module dpdbs_ctrl (
    input wire logic clk,
    input wire logic srst,
    input wire logic rdReq,
    input wire logic [9:0] rdAddr,
    input wire logic wrReq,
    input wire logic [9:0] wrAddr,
    input wire logic [35:0] wrData,
    input wire logic [3:0] wrMaskN,
    output logic [9:0] addr,
    output logic readPortSelectN,
    output logic writePortSelectN,
    output logic [17:0] writeData,
    output logic [1:0] byteWriteSelectN,
    output logic nextRead
);
    logic [17:0] upWord; // Second word of the pending write
    logic [1:0] upMaskN; // Lane enables of that word
    logic upDue; // Second word owed in the next read slot
    // Time-zero values, selects idle
    initial begin
        addr = '0;
        readPortSelectN = 1'b1;
        writePortSelectN = 1'b1;
        writeData = '0;
        byteWriteSelectN = 2'h3;
        upDue = 1'b0;
    end
    // Slot tracker mirrors the device side
    always @(posedge clk) nextRead <= srst | !nextRead;
    // Pins change at the falling edge, away from sampling
    always @(negedge clk) begin
        if (nextRead) begin
            // read address and select in the read slot
            addr <= rdReq ? rdAddr : ~addr;
            readPortSelectN <= !rdReq;
            writePortSelectN <= 1'b1;
            // second write word on the other edge
            writeData <= upDue ? upWord : ~writeData;
            byteWriteSelectN <= upDue ? upMaskN : 2'h3;
            upDue <= 1'b0;
        end else begin
            // write address, select and first word
            addr <= wrReq ? wrAddr : ~addr;
            readPortSelectN <= 1'b1;
            writePortSelectN <= !wrReq;
            // Idle bus shows a changing pattern, not the old word
            writeData <= wrReq ? wrData[17:0] : ~writeData;
            byteWriteSelectN <= wrMaskN[1:0];
            upWord <= wrData[35:18];
            upMaskN <= wrMaskN[3:2];
            upDue <= wrReq;
        end
    end
endmodule : dpdbs_ctrl

// ==== testbench/dual_port_ddr_burst2_sram_tb.sv ====
// Self-checking bench for the two-word burst SRAM
`timescale 1ns/10ps
module dual_port_ddr_burst2_sram_tb;
    logic clk = 1'b0;
    logic srst = 1'b1;
    logic pllModeSelect = 1'b0;
    logic rdReq = 1'b0;
    logic wrReq = 1'b0;
    logic [9:0] rdAddr = '0;
    logic [9:0] wrAddr = '0;
    logic [35:0] wrData = '0;
    logic [3:0] wrMaskN = '0;
    logic [9:0] addr;
    logic readSelN, writeSelN, nextRead, readValid, echo, echoN, writeBusy;
    logic [17:0] writeData, readData;
    logic [1:0] laneSelN;
    logic [35:0] refMem [1024]; // Reference array
    logic [35:0] expQ[$]; // Expected bursts
    logic [17:0] seenQ[$]; // Words seen on the read port
    int takeQ[$], seenEdge[$], edgeN, latN, badCount, nCompared;
    always #2 clk = ~clk;
    // Edge counter, edge 1 is the first after release
    always @(posedge clk) edgeN <= srst ? 0 : edgeN + 1;
    dpdbs_top u_dut (.clk(clk), .srst(srst),
        .pllModeSelect(pllModeSelect), .addr(addr),
        .readPortSelectN(readSelN), .writePortSelectN(writeSelN),
        .writeData(writeData), .byteWriteSelectN(laneSelN),
        .readData(readData), .readValid(readValid),
        .echoTimingOut(echo), .echoTimingOutN(echoN),
        .writeBusy(writeBusy));
    dpdbs_ctrl u_ctrl (.clk(clk), .srst(srst), .rdReq(rdReq),
        .rdAddr(rdAddr), .wrReq(wrReq), .wrAddr(wrAddr), .wrData(wrData),
        .wrMaskN(wrMaskN), .addr(addr), .readPortSelectN(readSelN),
        .writePortSelectN(writeSelN), .writeData(writeData),
        .byteWriteSelectN(laneSelN), .nextRead(nextRead));
    // Capture every word while the valid flag is up
    always @(negedge clk) begin
        if (readValid === 1'b1) begin
            seenQ.push_back(readData);
            seenEdge.push_back(edgeN);
        end
    end
    task automatic check(input logic [35:0] seen, input logic [35:0] exp);
        nCompared++;
        if (seen !== exp) begin
            badCount++;
            $display("Error at %0t: seen %0h expected %0h", $time, seen, exp);
        end
    endtask : check
    // One read slot then one write slot; reference updated after
    task automatic issue(input logic rd, input logic [9:0] ra,
        input logic wr, input logic [9:0] wa, input logic [35:0] wd,
        input logic [3:0] wm);
        while (nextRead !== 1'b1) begin
            @(posedge clk);
            #1;
        end
        rdReq = rd;
        rdAddr = ra;
        @(posedge clk);
        #1;
        if (rd) takeQ.push_back(edgeN);
        if (rd) expQ.push_back(refMem[ra]);
        rdReq = 1'b0;
        {wrReq, wrAddr, wrData, wrMaskN} = {wr, wa, wd, wm};
        @(posedge clk);
        #1;
        wrReq = 1'b0;
        // Disabled lanes keep their old contents
        for (int i = 0; i < 4; i++)
            if (wr && !wm[i]) refMem[wa][i*9 +: 9] = wd[i*9 +: 9];
    endtask : issue
    // Judge all bursts: count, order of words and latency
    task automatic drain();
        repeat (8) @(posedge clk);
        #1;
        check(36'(seenQ.size()), 36'(2 * expQ.size()));
        while (expQ.size() > 0 && seenQ.size() > 1) begin
            check({seenQ[1], seenQ[0]}, expQ.pop_front());
            check(36'(seenEdge[0]), 36'(takeQ[0] + latN));
            check(36'(seenEdge[1]), 36'(takeQ.pop_front() + latN + 1));
            repeat (2) seenQ.delete(0);
            repeat (2) seenEdge.delete(0);
        end
        seenQ.delete();
        expQ.delete();
    endtask : drain
    // Plain write then read back
    task automatic t_basic();
        issue(1'b0, 10'h000, 1'b1, 10'h005, 36'hA_BCDE_1234, 4'h0);
        issue(1'b1, 10'h005, 1'b0, 10'h000, 36'h0, 4'hF);
        drain();
    endtask : t_basic
    // Reads right behind writes, with lane masks
    task automatic t_coherent();
        issue(1'b0, 10'h000, 1'b1, 10'h3FF, 36'h1_1111_1111, 4'h0);
        issue(1'b1, 10'h3FF, 1'b1, 10'h3FF, 36'hE_EEEE_EEEE, 4'h5);
        issue(1'b1, 10'h3FF, 1'b1, 10'h3FF, 36'h7_7777_7777, 4'hF);
        issue(1'b1, 10'h3FF, 1'b0, 10'h000, 36'h0, 4'h0);
        drain();
    endtask : t_coherent
    // Write port busy every slot, read port gap with no select at i == 4
    task automatic t_concurrent();
        for (int i = 1; i < 9; i++)
            issue(i != 4, 10'(i + 4), 1'b1, 10'(i + 5),
                36'(i * 36'h3_0507_0B0D), 4'h0);
        issue(1'b0, 10'h000, 1'b0, 10'h000, 36'h0, 4'h0);
        drain();
    endtask : t_concurrent
    // Forty writes, more than the queue holds, with busy checked low; each read trails a write
    task automatic t_queue();
        for (int i = 0; i < 40; i++) begin
            issue(i > 0, 10'(i + 99), 1'b1, 10'(i + 100),
                {18'(i + 7), 18'(i * 3)}, 4'h0);
            check({35'h0, writeBusy}, 36'h0);
            // After a write-slot edge the echo is high only in long mode
            check({35'h0, echo}, 36'(pllModeSelect));
            check({35'h0, echoN}, 36'(!pllModeSelect));
        end
        drain();
        check({35'h0, readValid}, 36'h0);
    endtask : t_queue
    task automatic completeRun();
        $display("Compared %0d, mismatches %0d", nCompared, badCount);
        if (badCount == 0 && nCompared > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask : completeRun
    // Watchdog: far beyond the few hundred edges the tests need
    initial begin
        #40000;
        badCount++;
        completeRun();
    end
    // Both latency modes, mode changed only under reset
    initial begin
        for (int m = 0; m < 2; m++) begin
            @(negedge clk);
            srst = 1'b1;
            pllModeSelect = m[0];
            latN = 2 + m;
            repeat (12) @(negedge clk);
            srst = 1'b0;
            @(posedge clk);
            #1;
            t_basic();
            t_coherent();
            t_concurrent();
            t_queue();
        end
        completeRun();
    end
endmodule : dual_port_ddr_burst2_sram_tb
